// File: src/ssc_pkg.sv
// Package for the serial system control register bank: bit positions, resets, types.
package ssc_pkg;
  // Port addresses on the port-select lines
  localparam logic [2:0] PORT_CTRL_LO = 3'h0; // Lower control half
  localparam logic [2:0] PORT_ONE = 3'h1; // Port 1: upper half or serial/companding
  // Lower half bit positions
  localparam int FLAG_LSB = 0; // Interrupt flags 3..0
  localparam int EN_LSB = 4; // Interrupt enables 7..4
  localparam int NUM_IRQ = 4; // Sources: ext, rx frame, tx frame, internal frame
  localparam int BIT_ROUTE = 8; // Port-1 routing
  localparam int BIT_EXTFRM = 9; // External framing select
  localparam int BIT_FLAG = 10; // User output flag latch
  localparam int BIT_SPEN = 11; // Serial port enable
  localparam int BIT_ENC = 12; // Encoder enable
  localparam int BIT_DEC = 13; // Decoder enable
  localparam int BIT_LAW = 14; // 0 mu-255, 1 A-law
  localparam int BIT_SCLKIN = 15; // Serial clock direction
  // Upper half bit positions (relative to bit 16)
  localparam int MOD_LSB = 0; // Frame modulus 23..16
  localparam int PRE_LSB = 8; // Prescale 27..24
  localparam int BIT_WIDE = 12; // Frame pulse width, bit 28
  localparam int BIT_TWOS = 13; // Two's-complement companding, bit 29
  localparam int BIT_COPW = 14; // Coprocessor width, bit 30
  localparam int BIT_RSVD = 15; // Reserved, bit 31
  // Reset values
  localparam logic [15:0] LO_RESET = 16'h8000; // Serial clock input set, port enable clear
  localparam logic [15:0] HI_RESET = 16'h0000; // Format bit clear
  localparam logic [15:0] LO_W1C = 16'h000f; // Flag bits are write-one-to-clear
  localparam logic [15:0] HI_WMASK = 16'h7fff; // Reserved bit kept at zero
  localparam logic [7:0] FRM_LONG = 8'h08; // Long frame pulse length in serial clocks
  localparam logic [8:0] MOD_OFFSET = 9'h002; // Frame period is modulus plus two

  // Decoded configuration handed to serial and companding logic
  typedef struct packed {
    logic extFraming;
    logic serialEnable;
    logic encEnable;
    logic decEnable;
    logic aLaw;
    logic sclkIsInput;
    logic [7:0] frameModulus;
    logic [3:0] prescale;
    logic widePulse;
    logic twosComp;
    logic copWide;
    logic port1Route;
  } ssc_cfg_t;

  // Whole module state
  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic weDly;
    logic [3:0] preCnt;
    logic sclkOut;
    logic sclkInDly;
    logic [8:0] frmCnt;
    logic [7:0] pulseCnt;
    logic framePulse;
    logic [15:0] rdData;
  } ssc_state_t;
endpackage

// File: src/ssc_ctrl_regs.sv
// Serial system control register bank with peripheral-mode port strobes.
`timescale 1ns/1ps
// Functional notes
// - Four flags bits 3..0, enables 7..4
// - Flag always sets; enable gates interrupt
// - Route bit steers port 1 access
// - Framing bit picks internal or external pulses
// - Output flag pin follows latch bit
// - Serial enable gates shifter; reset clears
// - Encoder enable bit drives compression
// - Decoder enable bit drives expansion
// - Law bit: mu-255 or A-law
// - Serial clock direction; reset sets input
// - Frame rate is clock over modulus+2
// - Prescale field divides system clock
// - Width bit: one or eight clocks
// - Format bit: sign-magnitude or two's; reset clears
// - Width bit: byte or word coprocessor port
// - Peripheral mode: only these blocks run
// - Master interrupt drives branch-test pin in peripheral mode
// - Sync clock line is input in peripheral mode
// - Write strobe latches, read strobe drives
// - Bus driven only for ports 0,1
// - Write one clears flag; flags readable
// - Lower via port 0, upper via port 1
module ssc_ctrl_regs
  import ssc_pkg::*;
(
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic mode_select_pin, // Low selects peripheral mode
  input wire logic write_strobe_n, // Host write strobe, latch on rising edge
  input wire logic read_strobe_n, // Host read strobe
  input wire logic [2:0] port_select_lines, // Host port address
  input wire logic [15:0] dataIn, // Data bus input
  output logic [15:0] dataOut, // Data bus output
  output logic dataOe, // Data bus drive enable
  input wire logic external_interrupt_input, // Event pulses from synchronizer
  input wire logic rx_frame_sync,
  input wire logic tx_frame_sync,
  input wire logic sync_clock_line_in, // Sync clock from host in peripheral mode
  output logic sync_clock_line_out, // Sync clock driven in normal mode
  output logic sync_clock_line_oe,
  input wire logic serial_clock_in, // External serial clock level
  output logic serial_clock_out, // Divided serial clock
  output logic serial_clock_oe,
  output logic internal_frame_pulse, // Internal frame pulse
  output logic user_output_flag, // Output flag pin
  output logic branch_test_pin_out, // Master interrupt to host
  output logic branch_test_pin_oe,
  output logic irqOut, // Master interrupt
  output logic activeEn, // Low in peripheral mode: idle other logic
  output logic port1Write, // Port-1 write to serial/companding
  output logic port1Read, // Port-1 read from serial/companding
  input wire logic [15:0] port1RdData, // Serial/companding read data
  output logic txFrameSel, // Frame source for transmit
  output logic rxFrameSel, // Frame source for receive
  output ssc_cfg_t cfg // Decoded configuration
);
  ////////////////////////////////////////////////////////////////////////////
  // Limitations and intent
  // The host strobes are taken as synchronous to the system clock, so a write
  // is seen one cycle after the strobe returns high; no extra synchroniser.
  // Event inputs are level events: a source held high sets its flag every
  // cycle, so a write-one clear only sticks once the source has dropped.
  // The prescaler and frame counter run all the time; the framing source and
  // the serial enable only steer where the pulses go, which keeps the frame
  // phase steady while software reconfigures the port.
  // A frame modulus below eight or all ones is not refused here: software
  // must avoid it, the counter simply follows whatever value is loaded.
  // Bit 31 is forced to zero on every upper write rather than trusted.
  ssc_state_t st_r; // Registered state
  ssc_state_t st_nxt; // Next state
  logic periph; // Peripheral mode
  logic weRise; // Rising edge of write strobe
  logic rdActive; // Read strobe low
  logic [NUM_IRQ-1:0] evt; // Interrupt event inputs
  logic sclkTick; // One serial clock edge
  logic sclkInRise; // Rising edge of the external serial clock
  logic [8:0] framePeriod; // Frame length in serial clocks

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode
  assign periph = ~mode_select_pin;
  assign activeEn = ~periph;
  assign weRise = write_strobe_n & ~st_r.weDly;
  assign rdActive = ~read_strobe_n;
  assign evt = {st_r.framePulse, tx_frame_sync, rx_frame_sync, external_interrupt_input};
  assign sclkInRise = serial_clock_in & ~st_r.sclkInDly;
  assign framePeriod = {1'b0, st_r.hi[MOD_LSB +: 8]} + MOD_OFFSET;

  // Serial clock edge: divided system clock or external rising edge
  always_comb begin
    if (st_r.lo[BIT_SCLKIN]) begin
      sclkTick = sclkInRise;
    end else begin
      sclkTick = (st_r.preCnt == st_r.hi[PRE_LSB +: 4]) & st_r.sclkOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.weDly = write_strobe_n;
    st_nxt.sclkInDly = serial_clock_in;
    // Flags: the set wins over a write-one clear in the same cycle
    if (weRise && port_select_lines == PORT_CTRL_LO) begin
      st_nxt.lo = (dataIn & ~LO_W1C) | (st_r.lo & LO_W1C & ~dataIn);
    end
    if (weRise && port_select_lines == PORT_ONE && st_r.lo[BIT_ROUTE]) begin
      st_nxt.hi = dataIn & HI_WMASK;
    end
    st_nxt.lo[FLAG_LSB +: NUM_IRQ] = st_nxt.lo[FLAG_LSB +: NUM_IRQ] | evt;
    // Prescaler: toggles serial clock output when count hits the field
    if (st_r.preCnt == st_r.hi[PRE_LSB +: 4]) begin
      st_nxt.preCnt = 4'h0;
      st_nxt.sclkOut = ~st_r.sclkOut;
    end else begin
      st_nxt.preCnt = st_r.preCnt + 4'h1;
    end
    // Frame counter runs on serial clock in either direction
    // The pulse is set at the last count so that it leads the first bit
    // by one serial clock; a wide pulse then holds for eight ticks
    if (sclkTick) begin
      if (st_r.frmCnt >= framePeriod - 9'h001) begin
        st_nxt.frmCnt = 9'h000;
        st_nxt.framePulse = 1'b1;
        st_nxt.pulseCnt = st_r.hi[BIT_WIDE] ? FRM_LONG - 8'h01 : 8'h00;
      end else begin
        st_nxt.frmCnt = st_r.frmCnt + 9'h001;
        if (st_r.pulseCnt != 8'h00) begin
          st_nxt.pulseCnt = st_r.pulseCnt - 8'h01;
        end else begin
          st_nxt.framePulse = 1'b0;
        end
      end
    end
    // Read data captured for a registered bus output
    // Captured every cycle so the bus shows the port one cycle after the
    // address settles; this trades a cycle of latency for a clean output
    case (port_select_lines)
      PORT_CTRL_LO: st_nxt.rdData = st_r.lo;
      PORT_ONE: st_nxt.rdData = st_r.lo[BIT_ROUTE] ? st_r.hi : port1RdData;
      default: st_nxt.rdData = 16'h0000;
    endcase
  end

  // State register; reset loads documented values
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '{lo: LO_RESET, hi: HI_RESET, weDly: 1'b1, sclkInDly: 1'b0,
                rdData: 16'h0000, frmCnt: 9'h000, pulseCnt: 8'h00, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign irqOut = |(st_r.lo[FLAG_LSB +: NUM_IRQ] & st_r.lo[EN_LSB +: NUM_IRQ]);
  assign branch_test_pin_out = irqOut;
  assign branch_test_pin_oe = periph;
  assign sync_clock_line_out = st_r.sclkOut;
  assign sync_clock_line_oe = ~periph;
  assign serial_clock_out = st_r.sclkOut;
  assign serial_clock_oe = ~st_r.lo[BIT_SCLKIN];
  assign internal_frame_pulse = st_r.framePulse;
  assign user_output_flag = st_r.lo[BIT_FLAG];
  // Bus driven only while a port 0 or 1 read is under way
  assign dataOe = rdActive && (port_select_lines == PORT_CTRL_LO || port_select_lines == PORT_ONE);
  assign dataOut = st_r.rdData;
  // Port-1 data path to serial/companding when not routed to upper half
  assign port1Write = weRise && port_select_lines == PORT_ONE && !st_r.lo[BIT_ROUTE];
  assign port1Read = rdActive && port_select_lines == PORT_ONE && !st_r.lo[BIT_ROUTE];
  assign txFrameSel = st_r.lo[BIT_EXTFRM] ? tx_frame_sync : st_r.framePulse;
  assign rxFrameSel = st_r.lo[BIT_EXTFRM] ? rx_frame_sync : st_r.framePulse;
  assign cfg.extFraming = st_r.lo[BIT_EXTFRM];
  assign cfg.serialEnable = st_r.lo[BIT_SPEN];
  assign cfg.encEnable = st_r.lo[BIT_ENC];
  assign cfg.decEnable = st_r.lo[BIT_DEC];
  assign cfg.aLaw = st_r.lo[BIT_LAW];
  assign cfg.sclkIsInput = st_r.lo[BIT_SCLKIN];
  assign cfg.frameModulus = st_r.hi[MOD_LSB +: 8];
  assign cfg.prescale = st_r.hi[PRE_LSB +: 4];
  assign cfg.widePulse = st_r.hi[BIT_WIDE];
  assign cfg.twosComp = st_r.hi[BIT_TWOS];
  assign cfg.copWide = st_r.hi[BIT_COPW];
  assign cfg.port1Route = st_r.lo[BIT_ROUTE];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Each property watches state or outputs that this block drives.
  // They are all on the system clock; all but chk_reset_vals are quiet during reset.
  // Write to the lower half, taken on the strobe's return high
  sequence lowWrite;
    weRise && port_select_lines == PORT_CTRL_LO;
  endsequence
  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    evt[0] |=> st_r.lo[FLAG_LSB]) else $error("flag not set by event");
  chk_irq_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r.lo[FLAG_LSB] && !st_r.lo[EN_LSB] && st_r.lo[3:1] == 3'h0) |-> !irqOut) else $error("masked irq");
  chk_flag_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (lowWrite and (dataIn[0] && !evt[0])) |=> !st_r.lo[FLAG_LSB]) else $error("flag not cleared");
  chk_upper_blocked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (weRise && port_select_lines == PORT_ONE && !st_r.lo[BIT_ROUTE]) |=> $stable(st_r.hi)) else $error("upper written");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st_r.hi[BIT_RSVD]) else $error("reserved bit set");
  chk_bus_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (port_select_lines > PORT_ONE) |-> !dataOe) else $error("bus driven");
  chk_btp_irq: assert property (@(posedge ref_clk) disable iff (sys_rst)
    periph |-> (branch_test_pin_oe && branch_test_pin_out == irqOut)) else $error("branch pin");
  chk_flag_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (lowWrite) |=> user_output_flag == $past(dataIn[BIT_FLAG])) else $error("output flag");
  chk_reset_vals: assert property (@(posedge ref_clk)
    sys_rst |=> (st_r.lo[BIT_SCLKIN] && !st_r.lo[BIT_SPEN] && !st_r.hi[BIT_TWOS])) else $error("reset");

  // Write to the upper half, only while the route bit is set
  sequence upperWrite;
    weRise && port_select_lines == PORT_ONE && st_r.lo[BIT_ROUTE];
  endsequence
  // Last serial clock of a frame period
  sequence frameEnd;
    sclkTick && st_r.frmCnt >= framePeriod - 9'h001;
  endsequence
  // Host read of the lower half
  sequence lowRead;
    rdActive && port_select_lines == PORT_CTRL_LO;
  endsequence

  // An upper write lands with the reserved bit cleared
  // Checked against the bus value of the write cycle
  chk_upper_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    upperWrite |=> (st_r.hi == ($past(dataIn) & HI_WMASK))) else $error("upper write lost");

  // With the route bit clear, a port-1 read goes to the serial side
  // and the bus is still driven for it
  chk_port1_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rdActive && port_select_lines == PORT_ONE && !st_r.lo[BIT_ROUTE]) |-> (port1Read && dataOe))
    else $error("port1 read");

  // Reads of port 0 or 1 always drive the bus
  // Pairs with the float check above for the other ports
  chk_data_oe: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rdActive && port_select_lines <= PORT_ONE) |-> dataOe) else $error("bus not driven");

  // Two cycles of a port-0 read return the register as it stood
  // one cycle earlier
  chk_read_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (lowRead ##1 lowRead) |-> (dataOut == $past(st_r.lo))) else $error("read data");

  // End of a frame period raises the frame pulse
  // on the following cycle
  chk_frame_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    frameEnd |=> internal_frame_pulse) else $error("frame pulse missing");

  // Wide mode loads the count for eight serial clocks
  // at the start of each frame
  chk_wide_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (frameEnd ##0 st_r.hi[BIT_WIDE]) |=> (st_r.pulseCnt == FRM_LONG - 8'h01)) else $error("wide load");

  // An expired pulse count drops the pulse at the next tick
  // unless a new frame starts on that same tick
  chk_pulse_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sclkTick && st_r.pulseCnt == 8'h00 && st_r.frmCnt < framePeriod - 9'h001) |=> !internal_frame_pulse)
    else $error("pulse too long");

  // Internal framing sends the frame pulse to both directions
  // so transmit and receive move together
  chk_frame_mux: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st_r.lo[BIT_EXTFRM] |-> (txFrameSel == internal_frame_pulse && rxFrameSel == internal_frame_pulse))
    else $error("internal framing");

  // External framing routes each sync to its own direction
  chk_ext_frame: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r.lo[BIT_EXTFRM] |-> (txFrameSel == tx_frame_sync && rxFrameSel == rx_frame_sync))
    else $error("external framing");

  // The divided serial clock flips when the prescale count is reached
  // This is the only edge source while the clock is an output
  chk_prescale: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!st_r.lo[BIT_SCLKIN] && st_r.preCnt == st_r.hi[PRE_LSB +: 4]) |=> (serial_clock_out != $past(serial_clock_out)))
    else $error("prescale");

  // An enabled event raises the master interrupt next cycle
  // Writes are excluded since they may change the enables at once
  chk_irq_raise: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((|(evt & st_r.lo[EN_LSB +: NUM_IRQ])) && !weRise) |=> irqOut) else $error("irq not raised");
endmodule

// File: dv/ssc_host_model.sv
// Host processor model that drives the port strobes in peripheral mode.
`timescale 1ns/1ps
module ssc_host_model (
  input wire logic ref_clk, // System clock
  output logic write_strobe_n, // Write strobe, active low
  output logic read_strobe_n, // Read strobe, active low
  output logic [2:0] port_select_lines, // Port address
  output logic [15:0] dataIn, // Bus data toward the device
  input wire logic [15:0] dataOut, // Bus data from the device
  input wire logic dataOe // Device drive enable
);
  // Idle bus at time zero
  initial begin
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    port_select_lines = 3'h7;
    dataIn = 16'hffff;
  end
  // Strobe low one cycle, latch on the rise; bus shows inverse one cycle after release
  task automatic hostWrite(input logic [2:0] p, input logic [15:0] d);
    @(posedge ref_clk);
    write_strobe_n <= 1'b0;
    port_select_lines <= p;
    dataIn <= d;
    @(posedge ref_clk);
    write_strobe_n <= 1'b1;
    @(posedge ref_clk);
    dataIn <= ~d;
  endtask
  // Read data is registered one cycle behind the address, so wait two edges
  task automatic hostRead(input logic [2:0] p, output logic [15:0] d, output logic oe);
    @(posedge ref_clk);
    read_strobe_n <= 1'b0;
    port_select_lines <= p;
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    d = dataOut;
    oe = dataOe;
    @(posedge ref_clk);
    read_strobe_n <= 1'b1;
  endtask
endmodule

// File: dv/ssc_ctrl_regs_bench.sv
// Self-checking bench for the serial system control register bank.
`timescale 1ns/1ps
module ssc_ctrl_regs_bench;
  import ssc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wrN, rdN, ext = 1'b0, rxf = 1'b0, txf = 1'b0, oe, dOe, irq, p1w, p1r;
  logic [2:0] sel;
  logic [15:0] din, dout, rd;
  logic sclkO, sclkOe, syncO, syncOe, frm, flagPin, btO, btOe, actEn, txSel, rxSel;
  ssc_cfg_t cfg;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling far above the expected run length
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Device and host; mode pin tied low for peripheral mode
  ssc_ctrl_regs i_ssc_ctrl_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode_select_pin(1'b0),
    .write_strobe_n(wrN), .read_strobe_n(rdN), .port_select_lines(sel), .dataIn(din),
    .dataOut(dout), .dataOe(dOe), .external_interrupt_input(ext), .rx_frame_sync(rxf),
    .tx_frame_sync(txf), .sync_clock_line_in(1'b0), .sync_clock_line_out(syncO),
    .sync_clock_line_oe(syncOe), .serial_clock_in(1'b0), .serial_clock_out(sclkO),
    .serial_clock_oe(sclkOe), .internal_frame_pulse(frm), .user_output_flag(flagPin),
    .branch_test_pin_out(btO), .branch_test_pin_oe(btOe), .irqOut(irq), .activeEn(actEn),
    .port1Write(p1w), .port1Read(p1r), .port1RdData(16'h5a3c), .txFrameSel(txSel),
    .rxFrameSel(rxSel), .cfg(cfg));
  ssc_host_model host (.ref_clk(ref_clk), .write_strobe_n(wrN), .read_strobe_n(rdN),
    .port_select_lines(sel), .dataIn(din), .dataOut(dout), .dataOe(dOe));
  ////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reset values and peripheral-mode pin roles
  task automatic t_reset();
    host.hostRead(PORT_CTRL_LO, rd, oe);
    chk(rd, LO_RESET);
    chk(oe, 1'b1);
    chk(sclkOe, 1'b0);
    chk({actEn, syncOe, btOe}, 3'h1);
    $display("t_reset done");
  endtask
  // Lower-half fields reach their outputs
  task automatic t_lower();
    // Serial clock stays an input here, so no internal frames set flag 3
    host.hostWrite(PORT_CTRL_LO, 16'hf6f0);
    host.hostRead(PORT_CTRL_LO, rd, oe);
    chk(rd, 16'hf6f0);
    chk(flagPin, 1'b1);
    chk({cfg.aLaw, cfg.encEnable, cfg.decEnable, cfg.extFraming}, 4'hf);
    chk(sclkOe, 1'b0);
    $display("t_lower done");
  endtask
  // Flags set with or without enable; write one clears
  task automatic t_irq();
    @(posedge ref_clk) ext <= 1'b1;
    @(posedge ref_clk) ext <= 1'b0;
    @(posedge ref_clk) #1;
    chk({irq, btO}, 2'h3);
    host.hostWrite(PORT_CTRL_LO, 16'h8001);
    @(posedge ref_clk) rxf <= 1'b1;
    @(posedge ref_clk) rxf <= 1'b0;
    host.hostRead(PORT_CTRL_LO, rd, oe);
    chk(rd, 16'h8002);
    chk(irq, 1'b0);
    $display("t_irq done");
  endtask
  // Port-1 routing, upper-half fields and the reserved bit
  task automatic t_upper();
    host.hostRead(PORT_ONE, rd, oe);
    chk(rd, 16'h5a3c);
    host.hostWrite(PORT_CTRL_LO, 16'h8100);
    host.hostWrite(PORT_ONE, 16'hf00a);
    host.hostRead(PORT_ONE, rd, oe);
    chk(rd, 16'h700a);
    chk(cfg.frameModulus, 8'h0a);
    chk({cfg.prescale, cfg.widePulse, cfg.twosComp, cfg.copWide}, 7'h07);
    host.hostRead(3'h3, rd, oe);
    chk(oe, 1'b0);
    $display("t_upper done");
  endtask
  // Internal frame pulse: modulus 10, wide pulse, prescale 0 (serial clock = 2 system clocks)
  task automatic t_frame();
    int hiCnt;
    int per;
    hiCnt = 0;
    per = 0;
    host.hostWrite(PORT_CTRL_LO, 16'h0102);
    @(posedge ref_clk);
    #1;
    chk(sclkOe, 1'b1);
    while (frm !== 1'b0) begin
      @(posedge ref_clk);
      #1;
    end
    while (frm !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    chk({txSel, rxSel}, 2'h3);
    while (frm === 1'b1) begin
      @(posedge ref_clk);
      #1;
      hiCnt = hiCnt + 1;
    end
    per = hiCnt;
    while (frm === 1'b0) begin
      @(posedge ref_clk);
      #1;
      per = per + 1;
    end
    chk(hiCnt, 32'd16);
    chk(per, 32'd24);
    host.hostRead(PORT_CTRL_LO, rd, oe);
    chk(rd, 16'h0108);
    $display("t_frame done");
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_lower();
    t_irq();
    t_upper();
    t_frame();
    test_done();
  end
endmodule
